// *** rtl/bqf_cfg.svh ***
`ifndef BQF_CFG_SVH
`define BQF_CFG_SVH

// ----------------------------------------
// register byte offsets on the bus
// ----------------------------------------
`define BQF_OFF_CTRL 8'h00
`define BQF_OFF_AFOFF 8'h04
`define BQF_OFF_AETH 8'h08
`define BQF_OFF_LEVEL 8'h0c
`define BQF_OFF_STAT 8'h10
`define BQF_OFF_MASK 8'h14

// ----------------------------------------
// field positions
// ----------------------------------------
`define BQF_CTRL_FLUSH 0
`define BQF_EV_OVF 0
`define BQF_EV_UNF 1
`define BQF_EV_FULL 2
`define BQF_EV_EMPTY 3
`define BQF_WARN_LOW_TH 16
`define BQF_WARN_HIGH_TH 17

// ----------------------------------------
// reset values
// ----------------------------------------
`define BQF_AFOFF_RST 14'h0001
`define BQF_AETH_RST 14'h0001
`define BQF_MASK_RST 4'h0
`define BQF_STAT_RST 4'h0

`endif

// *** rtl/bqf_fifo.sv ***
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "bqf_cfg.svh"

module bqf_fifo #(
    parameter int WIDTH = 36,
    parameter int ADDR_W = 8,
    parameter bit OUT_REG = 1'b0,
    parameter bit RESET_ASYNC = 1'b1,
    parameter logic [2:0] WR_MATCH = 3'h0,
    parameter logic [2:0] RD_MATCH = 3'h0
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CLK_EN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    output logic IRQ,
    input wire logic WR_EN,
    input wire logic [2:0] WR_SEL,
    input wire logic [WIDTH-1:0] WR_WORD,
    input wire logic RD_EN,
    input wire logic [2:0] RD_SEL,
    output logic [WIDTH-1:0] RD_WORD,
    output logic RD_VALID,
    output logic FULL_FLAG,
    output logic ALMOST_FULL_FLAG,
    output logic EMPTY_FLAG,
    output logic ALMOST_EMPTY_FLAG
);

    localparam int DEPTH = 1 << ADDR_W;

    // ----------------------------------------
    // storage and fifo state
    // ----------------------------------------
    logic [WIDTH-1:0] mem [DEPTH]; // array, never reset
    logic [ADDR_W:0] wptr_q, wptr_d, rptr_q, rptr_d; // extra msb tells full from empty
    logic wpend_q, wpend_d; // registered write pending
    logic [ADDR_W-1:0] waddr_q, waddr_d;
    logic [WIDTH-1:0] wdata_q, wdata_d;
    logic [WIDTH-1:0] s1_q, s1_d, out_q, out_d; // read stage and output
    logic s1v_q, s1v_d, outv_q, outv_d;
    logic full_q, full_d, afull_q, afull_d, empty_q, empty_d, aempty_q, aempty_d;
    logic [ADDR_W:0] level_d; // fill level after this edge
    logic wr_ok, rd_ok, flush; // accepted requests, soft reset
    logic [3:0] ev; // event pulses
    logic [WIDTH-1:0] rd_val;

    bqf_pkg::bqf_cfg_s cfg_q, cfg_d;
    bqf_pkg::bqf_bus_s bus_q, bus_d;
    logic [31:0] rd_mux; // register read value

    // ----------------------------------------
    // fifo next state
    // ----------------------------------------
    always_comb
    begin
        // requests honoured only on a decode match and an open flag
        wr_ok = WR_EN && (WR_SEL == WR_MATCH) && !full_q;
        rd_ok = RD_EN && (RD_SEL == RD_MATCH) && !empty_q;
        wptr_d = wptr_q;
        rptr_d = rptr_q;
        // write data and address land in input registers first
        wpend_d = wr_ok;
        waddr_d = wr_ok ? wptr_q[ADDR_W-1:0] : waddr_q;
        wdata_d = wr_ok ? WR_WORD : wdata_q;
        // a read of the word still in the input register takes it from there
        if (wpend_q && (waddr_q == rptr_q[ADDR_W-1:0]))
        begin
            rd_val = wdata_q;
        end
        else
        begin
            rd_val = mem[rptr_q[ADDR_W-1:0]];
        end
        s1_d = rd_ok ? rd_val : s1_q;
        s1v_d = rd_ok;
        // output register mode adds one stage
        out_d = OUT_REG ? s1_q : s1_d;
        outv_d = OUT_REG ? s1v_q : s1v_d;
        if (wr_ok)
        begin
            wptr_d = wptr_q + (ADDR_W + 1)'(1);
        end
        if (rd_ok)
        begin
            rptr_d = rptr_q + (ADDR_W + 1)'(1);
        end
        if (flush)
        begin
            // pointers home, pending write dropped, array kept
            wptr_d = '0;
            rptr_d = '0;
            wpend_d = 1'b0;
        end
        // one clock, so binary pointers compare safely without gray crossing
        level_d = wptr_d - rptr_d;
        full_d = (level_d == (ADDR_W + 1)'(DEPTH));
        empty_d = (level_d == '0);
        // offset zero makes almost-full equal full, threshold zero equal empty
        afull_d = (15'(level_d) + 15'(cfg_q.af_off)) >= 15'(DEPTH);
        aempty_d = 15'(level_d) <= 15'(cfg_q.ae_th);
        ev = '0;
        ev[`BQF_EV_OVF] = WR_EN && (WR_SEL == WR_MATCH) && full_q;
        ev[`BQF_EV_UNF] = RD_EN && (RD_SEL == RD_MATCH) && empty_q;
        ev[`BQF_EV_FULL] = full_d && !full_q;
        ev[`BQF_EV_EMPTY] = empty_d && !empty_q && !flush;
    end

    // ----------------------------------------
    // array write port, contents survive reset
    // ----------------------------------------
    always_ff @(posedge SYS_CLK)
    begin
        if (CLK_EN && wpend_q && !RST)
        begin
            mem[waddr_q] <= wdata_q;
        end
    end

    // ----------------------------------------
    // bus and register next state
    // ----------------------------------------
    always_comb
    begin
        bus_d = bus_q;
        cfg_d = cfg_q;
        flush = 1'b0;
        rd_mux = 32'h0000_0000; // unmapped reads return zero
        case (bus_q.addr)
            `BQF_OFF_AFOFF: rd_mux = {18'h0, cfg_q.af_off};
            `BQF_OFF_AETH: rd_mux = {18'h0, cfg_q.ae_th};
            `BQF_OFF_LEVEL:
            begin
                rd_mux[13:0] = 14'(wptr_q - rptr_q);
                rd_mux[`BQF_WARN_LOW_TH] = (cfg_q.ae_th == 14'h0000);
                rd_mux[`BQF_WARN_HIGH_TH] = (cfg_q.af_off == 14'h0000);
            end
            `BQF_OFF_STAT: rd_mux = {28'h0, cfg_q.stat};
            `BQF_OFF_MASK: rd_mux = {28'h0, cfg_q.mask};
            default: rd_mux = 32'h0000_0000;
        endcase
        // events set, write-one clears, set wins
        cfg_d.stat = cfg_q.stat | ev;
        case (bus_q.phase)
            bqf_pkg::BQF_WR:
            begin
                // data phase of a write, no wait state
                bus_d.phase = bqf_pkg::BQF_IDLE;
                case (bus_q.addr)
                    `BQF_OFF_CTRL: flush = HWDATA[`BQF_CTRL_FLUSH];
                    `BQF_OFF_AFOFF: cfg_d.af_off = HWDATA[13:0];
                    `BQF_OFF_AETH: cfg_d.ae_th = HWDATA[13:0];
                    `BQF_OFF_STAT: cfg_d.stat = (cfg_q.stat & ~HWDATA[3:0]) | ev;
                    `BQF_OFF_MASK: cfg_d.mask = HWDATA[3:0];
                    default: flush = 1'b0; // unmapped writes dropped
                endcase
            end
            bqf_pkg::BQF_RD:
            begin
                // one wait state lets read data leave a flop
                bus_d.rdata = rd_mux;
                bus_d.hrdy = 1'b1;
                bus_d.phase = bqf_pkg::BQF_IDLE;
            end
            default:
            begin
                bus_d.phase = bqf_pkg::BQF_IDLE;
            end
        endcase
        // new address phase taken when selected, HTRANS[1] set and the bus ready
        if (HSEL && HTRANS[1] && HREADY)
        begin
            bus_d.addr = HADDR[7:0];
            bus_d.phase = HWRITE ? bqf_pkg::BQF_WR : bqf_pkg::BQF_RD;
            bus_d.hrdy = HWRITE;
        end
        bus_d.irq = |(cfg_d.stat & cfg_d.mask);
    end

    // ----------------------------------------
    // state registers, reset type by parameter
    // ----------------------------------------
    generate
        if (RESET_ASYNC)
        begin : g_arst
            // asynchronous clear of control and data registers, ram array not cleared
            always_ff @(posedge SYS_CLK or posedge RST)
            begin
                if (RST)
                begin
                    wptr_q <= '0;
                    rptr_q <= '0;
                    wpend_q <= 1'b0;
                    waddr_q <= '0;
                    wdata_q <= '0;
                    s1_q <= '0;
                    s1v_q <= 1'b0;
                    out_q <= '0;
                    outv_q <= 1'b0;
                    full_q <= 1'b0;
                    afull_q <= 1'b0;
                    empty_q <= 1'b1;
                    aempty_q <= 1'b1;
                    cfg_q <= {`BQF_AFOFF_RST, `BQF_AETH_RST, `BQF_MASK_RST, `BQF_STAT_RST};
                    bus_q <= {bqf_pkg::BQF_IDLE, 8'h00, 1'b1, 32'h0000_0000, 1'b0};
                end
                else if (CLK_EN)
                begin
                    wptr_q <= wptr_d;
                    rptr_q <= rptr_d;
                    wpend_q <= wpend_d;
                    waddr_q <= waddr_d;
                    wdata_q <= wdata_d;
                    s1_q <= s1_d;
                    s1v_q <= s1v_d;
                    out_q <= out_d;
                    outv_q <= outv_d;
                    full_q <= full_d;
                    afull_q <= afull_d;
                    empty_q <= empty_d;
                    aempty_q <= aempty_d;
                    cfg_q <= cfg_d;
                    bus_q <= bus_d;
                end
            end
        end
        else
        begin : g_srst
            // clocked clear, same values
            always_ff @(posedge SYS_CLK)
            begin
                if (RST)
                begin
                    wptr_q <= '0;
                    rptr_q <= '0;
                    wpend_q <= 1'b0;
                    waddr_q <= '0;
                    wdata_q <= '0;
                    s1_q <= '0;
                    s1v_q <= 1'b0;
                    out_q <= '0;
                    outv_q <= 1'b0;
                    full_q <= 1'b0;
                    afull_q <= 1'b0;
                    empty_q <= 1'b1;
                    aempty_q <= 1'b1;
                    cfg_q <= {`BQF_AFOFF_RST, `BQF_AETH_RST, `BQF_MASK_RST, `BQF_STAT_RST};
                    bus_q <= {bqf_pkg::BQF_IDLE, 8'h00, 1'b1, 32'h0000_0000, 1'b0};
                end
                else if (CLK_EN)
                begin
                    wptr_q <= wptr_d;
                    rptr_q <= rptr_d;
                    wpend_q <= wpend_d;
                    waddr_q <= waddr_d;
                    wdata_q <= wdata_d;
                    s1_q <= s1_d;
                    s1v_q <= s1v_d;
                    out_q <= out_d;
                    outv_q <= outv_d;
                    full_q <= full_d;
                    afull_q <= afull_d;
                    empty_q <= empty_d;
                    aempty_q <= aempty_d;
                    cfg_q <= cfg_d;
                    bus_q <= bus_d;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // outputs from flops, except HRESP tied low
    // ----------------------------------------
    assign HRDATA = bus_q.rdata;
    assign HREADYOUT = bus_q.hrdy;
    assign HRESP = 1'b0; // always OKAY
    assign IRQ = bus_q.irq;
    assign RD_WORD = out_q;
    assign RD_VALID = outv_q;
    assign FULL_FLAG = full_q;
    assign ALMOST_FULL_FLAG = afull_q;
    assign EMPTY_FLAG = empty_q;
    assign ALMOST_EMPTY_FLAG = aempty_q;

endmodule

// *** rtl/bqf_pkg.sv ***
package bqf_pkg;

    // bus slave phase, one-hot
    typedef enum logic [2:0]
    {
        BQF_IDLE = 3'b001,
        BQF_WR = 3'b010,
        BQF_RD = 3'b100
    } bqf_phase_e;

    // software-visible settings and event state
    typedef struct packed
    {
        logic [13:0] af_off; // almost_full_threshold, offset below depth
        logic [13:0] ae_th; // almost_empty_threshold
        logic [3:0] mask; // interrupt mask
        logic [3:0] stat; // sticky events
    } bqf_cfg_s;

    // bus slave state
    typedef struct packed
    {
        bqf_phase_e phase;
        logic [7:0] addr;
        logic hrdy;
        logic [31:0] rdata;
        logic irq;
    } bqf_bus_s;

endpackage

// *** tb/bqf_fifo_sva.sv ***
`timescale 1ns/1ps
// ----
// port checker
// ----
module bqf_fifo_chk #(parameter int ADDR_W = 8, parameter bit OUT_REG = 1'b0,
    parameter logic [2:0] WR_MATCH = 3'h0, parameter logic [2:0] RD_MATCH = 3'h0) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CLK_EN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic WR_EN,
    input wire logic [2:0] WR_SEL,
    input wire logic RD_EN,
    input wire logic [2:0] RD_SEL,
    input wire logic RD_VALID,
    input wire logic FULL_FLAG,
    input wire logic ALMOST_FULL_FLAG,
    input wire logic EMPTY_FLAG,
    input wire logic ALMOST_EMPTY_FLAG
);
    localparam int LAT = 1 + OUT_REG;
    localparam int DEPTH = 1 << ADDR_W;
    logic [ADDR_W:0] lvl_q, lvl_d; // fill level from accepted traffic
    logic fl_q, fl_d; // ctrl write in its data phase
    logic wa, ra; // accepted write and read this edge
    assign wa = CLK_EN && WR_EN && WR_SEL == WR_MATCH && !FULL_FLAG;
    assign ra = CLK_EN && RD_EN && RD_SEL == RD_MATCH && !EMPTY_FLAG;
    // flush zeroes the level; traffic in that cycle is not modelled
    always_comb
    begin
        fl_d = CLK_EN ? HSEL && HTRANS[1] && HREADY && HWRITE && HADDR[7:0] == 8'h00 : fl_q;
        lvl_d = lvl_q + (ADDR_W + 1)'(wa) - (ADDR_W + 1)'(ra);
        if (fl_q && CLK_EN && HWDATA[0])
            lvl_d = '0;
        if (RST)
            lvl_d = '0;
        if (RST)
            fl_d = 1'b0;
    end
    always_ff @(posedge SYS_CLK)
    begin
        lvl_q <= lvl_d;
        fl_q <= fl_d;
    end
    // ----
    // assertions
    // ----
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    sequence s_rd_take;
        CLK_EN && HSEL && HTRANS[1] && HREADY && !HWRITE;
    endsequence
    sequence s_rd_wait;
        !HREADYOUT ##1 HREADYOUT;
    endsequence
    property p_rd_wait; s_rd_take |=> s_rd_wait; endproperty
    property p_wr_nowait; CLK_EN && HSEL && HTRANS[1] && HREADY && HWRITE |=> HREADYOUT;
    endproperty
    property p_okay; HRESP == 1'b0; endproperty
    property p_out_rst; $fell(RST) |-> EMPTY_FLAG && ALMOST_EMPTY_FLAG && !FULL_FLAG
        && !ALMOST_FULL_FLAG && !RD_VALID; endproperty
    property p_empty; EMPTY_FLAG == (lvl_q == 0); endproperty
    property p_full; FULL_FLAG == (lvl_q == DEPTH); endproperty
    property p_aempty; EMPTY_FLAG |-> ALMOST_EMPTY_FLAG; endproperty
    property p_afull; FULL_FLAG |-> ALMOST_FULL_FLAG; endproperty
    property p_rd_ans; ra |-> ##LAT RD_VALID; endproperty
    property p_rd_src; RD_VALID |-> $past(ra, LAT); endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait not one cycle");
    a_wr_nowait: assert property (p_wr_nowait) else $error("write phase stalled");
    a_okay: assert property (p_okay) else $error("error response seen");
    a_out_rst: assert property (p_out_rst) else $error("flags wrong after reset");
    a_empty: assert property (p_empty) else $error("empty flag off level");
    a_full: assert property (p_full) else $error("full flag off level");
    a_aempty: assert property (p_aempty) else $error("almost empty low while empty");
    a_afull: assert property (p_afull) else $error("almost full low while full");
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    a_rd_src: assert property (p_rd_src) else $error("read valid without read");
endmodule

bind bqf_fifo bqf_fifo_chk #(.ADDR_W(ADDR_W), .OUT_REG(OUT_REG), .WR_MATCH(WR_MATCH),
    .RD_MATCH(RD_MATCH)) u_chk (.SYS_CLK(SYS_CLK), .RST(RST), .CLK_EN(CLK_EN), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .WR_EN(WR_EN), .WR_SEL(WR_SEL), .RD_EN(RD_EN),
    .RD_SEL(RD_SEL), .RD_VALID(RD_VALID), .FULL_FLAG(FULL_FLAG),
    .ALMOST_FULL_FLAG(ALMOST_FULL_FLAG), .EMPTY_FLAG(EMPTY_FLAG),
    .ALMOST_EMPTY_FLAG(ALMOST_EMPTY_FLAG));

// *** tb/bqf_fifo_tb.sv ***
`timescale 1ns/1ps
module bqf_fifo_tb;
    localparam int DEPTH = 256;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr_go = 1'b0;
    logic rd_go = 1'b0;
    logic [35:0] wr_val = '0;
    logic [2:0] wsel = 3'h0;
    logic [2:0] rsel = 3'h0; // read select, mismatch refuses reads
    logic clk_en = 1'b1; // low freezes the whole block
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [31:0] r;
    logic [31:0] lf = 32'h5b; // lfsr state, fixed seed
    logic [31:0] hrdata;
    logic hready, irq, wr_en, rd_en, rd_valid;
    logic full_flag, almost_full_flag, empty_flag, almost_empty_flag;
    logic [35:0] wr_word, rd_word;
    logic [35:0] q[$]; // words held by the model
    logic [35:0] rq[$]; // words read, not yet seen
    bit aw, ar;
    int n_mismatch = 0;
    int tests_run = 0;
    int lvl = 0;
    initial
    begin
        forever #20 clk = ~clk;
    end
    bqf_fifo dut (.SYS_CLK(clk), .RST(rst), .CLK_EN(clk_en), .HSEL(1'b1), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
        .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(), .IRQ(irq), .WR_EN(wr_en),
        .WR_SEL(wsel), .WR_WORD(wr_word), .RD_EN(rd_en), .RD_SEL(rsel), .RD_WORD(rd_word),
        .RD_VALID(rd_valid), .FULL_FLAG(full_flag), .ALMOST_FULL_FLAG(almost_full_flag),
        .EMPTY_FLAG(empty_flag), .ALMOST_EMPTY_FLAG(almost_empty_flag));
    bqf_user u_usr (.clk(clk), .wr_go(wr_go), .wr_val(wr_val), .rd_go(rd_go),
        .wr_en(wr_en), .wr_word(wr_word), .rd_en(rd_en));
    // ----
    // helpers
    // ----
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [35:0] e, input logic [35:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic flags(input logic [3:0] e); // full, almost full, empty, almost empty
        chk({32'h0, e}, {32'h0, full_flag, almost_full_flag, empty_flag, almost_empty_flag});
    endtask
    // one single transfer; waits for hready at both phases
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    // mode bit1 = every cycle, bit0 = random stall
    task automatic traffic(input int n, input logic [1:0] wm, input logic [1:0] rm);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk);
            lf = nxt(lf);
            wr_go <= wm[1] | (wm[0] & lf[0]);
            rd_go <= rm[1] | (rm[0] & lf[1]);
            wr_val <= {lf[7:4], lf};
        end
        @(posedge clk);
        wr_go <= 1'b0;
        rd_go <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task final_report;
        $display("mismatches=%0d compares=%0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // scoreboard: acceptance from the model level, data order checked on valid
    always @(posedge clk)
    begin
        if (rd_valid === 1'b1)
            chk(rq.pop_front(), rd_word);
        aw = clk_en === 1'b1 && wr_en === 1'b1 && wsel == 3'h0 && lvl < DEPTH;
        ar = clk_en === 1'b1 && rd_en === 1'b1 && rsel == 3'h0 && lvl > 0;
        if (rst === 1'b1)
        begin
            q.delete();
            rq.delete();
            lvl = 0;
        end
        else
        begin
            if (ar)
                rq.push_back(q.pop_front());
            if (aw)
                q.push_back(wr_word);
            lvl = lvl + int'(aw) - int'(ar);
        end
    end
    initial
    begin
        #(40 * 20000);
        n_mismatch++;
        final_report();
    end
    // ----
    // main sequence
    // ----
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        flags(4'b0011);
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b0, 8'h04 + 8'(4 * i), 32'h0);
            chk(36'(i < 2), {4'h0, r});
        end
        bus(1'b1, 8'h04, 32'h0000000c);
        bus(1'b1, 8'h08, 32'h00000004);
        traffic(DEPTH - 13, 2'h2, 2'h0);
        flags(4'b0000);
        traffic(1, 2'h2, 2'h0);
        flags(4'b0100);
        traffic(14, 2'h2, 2'h0);
        flags(4'b1100);
        bus(1'b0, 8'h10, 32'h0);
        chk(36'h5, {33'h0, r[2:0]});
        bus(1'b0, 8'h0c, 32'h0);
        chk(36'h100, {22'h0, r[13:0]});
        chk(36'h0, {35'h0, irq});
        bus(1'b1, 8'h14, 32'h1);
        repeat (2) @(posedge clk);
        chk(36'h1, {35'h0, irq});
        bus(1'b1, 8'h10, 32'h1);
        repeat (2) @(posedge clk);
        chk(36'h0, {35'h0, irq});
        traffic(DEPTH - 5, 2'h0, 2'h2);
        flags(4'b0000);
        traffic(1, 2'h0, 2'h2);
        flags(4'b0001);
        traffic(6, 2'h0, 2'h2);
        flags(4'b0011);
        bus(1'b0, 8'h10, 32'h0);
        chk(36'h2, {35'h0, r[1]} << 1);
        wsel <= 3'h1;
        traffic(3, 2'h2, 2'h0);
        flags(4'b0011);
        wsel <= 3'h0;
        traffic(5, 2'h2, 2'h0);
        // reads with a foreign select must leave the level alone
        rsel <= 3'h1;
        traffic(3, 2'h0, 2'h2);
        flags(4'b0000);
        rsel <= 3'h0;
        // frozen block takes neither writes nor reads
        clk_en <= 1'b0;
        traffic(3, 2'h2, 2'h2);
        clk_en <= 1'b1;
        bus(1'b0, 8'h0c, 32'h0);
        chk(36'h5, {22'h0, r[13:0]});
        bus(1'b1, 8'h00, 32'h1);
        q.delete();
        lvl = 0;
        @(posedge clk);
        flags(4'b0011);
        bus(1'b1, 8'h08, 32'h0);
        bus(1'b0, 8'h0c, 32'h0);
        chk(36'h10000, {18'h0, r[17:0]});
        // zero threshold falls back to empty: one word clears almost empty
        traffic(1, 2'h2, 2'h0);
        flags(4'b0000);
        traffic(400, 2'h1, 2'h1);
        traffic(DEPTH, 2'h0, 2'h2);
        flags(4'b0011);
        traffic(4, 2'h2, 2'h0);
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        flags(4'b0011);
        bus(1'b0, 8'h08, 32'h0);
        chk(36'h1, {4'h0, r});
        final_report();
    end
endmodule

// *** tb/bqf_user.sv ***
`timescale 1ns/1ps
// ----
// producer and consumer
// ----
module bqf_user #(parameter int W = 36) (
    input wire logic clk,
    input wire logic wr_go,
    input wire logic [W-1:0] wr_val,
    input wire logic rd_go,
    output logic wr_en,
    output logic [W-1:0] wr_word,
    output logic rd_en
);
    initial
    begin
        wr_en = 1'b0;
        wr_word = '0;
        rd_en = 1'b0;
    end
    // requests move only just after an edge; idle data flips so it never looks held
    always @(posedge clk)
    begin
        wr_en <= wr_go;
        wr_word <= wr_go ? wr_val : ~wr_word;
        rd_en <= rd_go;
    end
endmodule
